// *** design/sobs_consts.svh ***
`ifndef SOBS_CONSTS_SVH
`define SOBS_CONSTS_SVH

// Register word offsets (byte addresses).
`define SOBS_OFS_SEQ_SEL     5'h00
`define SOBS_OFS_MAIN_SEL    5'h04
`define SOBS_OFS_STALL_DLY   5'h08
`define SOBS_OFS_RUN_DLY     5'h0c
`define SOBS_OFS_ESTOP_TQ    5'h10
`define SOBS_OFS_NORM_TQ     5'h14
`define SOBS_OFS_STATUS      5'h18

// Reset values.
`define SOBS_RST_SEL         4'h0
`define SOBS_RST_DLY         7'h00
`define SOBS_RST_ESTOP_TQ    10'h000
`define SOBS_RST_NORM_TQ     10'h12c

// Setting limits.
`define SOBS_MAX_SEL         4'h9
`define SOBS_MAX_DLY         7'h64
`define SOBS_MAX_TQ          10'h1f4
`define SOBS_HOLD_SEL_LO     4'h4
`define SOBS_ESTOP_SEL_LO    4'h8
`define SOBS_LOW_SPEED_RPM   16'h001e

// Status field positions.
`define SOBS_ST_BRAKE_BIT    0
`define SOBS_ST_ENERG_BIT    1
`define SOBS_ST_DECEL_BIT    2
`define SOBS_ST_LOWSPD_BIT   3

// Delay time base: one count is 2 ms.
`define SOBS_UNIT_NS         2000000
`define SOBS_CLK_PERIOD_NS   10
`define SOBS_UNIT_CYCLES     (`SOBS_UNIT_NS / `SOBS_CLK_PERIOD_NS)

`endif

// *** design/sobs_pkg.sv ***
package sobs_pkg;

   typedef enum logic [1:0] {
      SOBS_STOP_DB,
      SOBS_STOP_FREE,
      SOBS_STOP_ESTOP
   } sobs_stop_t;

   typedef struct packed {
      sobs_stop_t decel;
      sobs_stop_t after;
      logic       clearCounter;
   } sobs_action_t;

   typedef enum {
      SOBS_SERVO_ON,
      SOBS_STALL_WAIT,
      SOBS_RUN_WAIT,
      SOBS_SERVO_OFF
   } sobs_state_t;

endpackage

// *** design/sobs_sequencer.sv ***
`timescale 1ns/10ps
`include "sobs_consts.svh"

// Overview of operation
// [RULE_01] A servo-off sequence selector holds 0 to 9, resets to 0, and sets deceleration, after-stall and counter actions.
// [RULE_02] The servo-off selector is decoded exactly as the main-power-off selector is.
// [RULE_03] Values 0-3 pick braking or free-run per phase and clear, 4-7 do the same but hold, 8-9 use emergency stop then clear.
// [RULE_04] With selector 8 or 9 the deceleration torque limit is the emergency setting, or the normal limit if that is zero.
// [RULE_05] A stalled servo-off drops brake release first and keeps the motor energized for the stall delay in 2 ms counts.
// [RULE_06] The host sets the stall delay no shorter than the brake's action delay and requests servo-off after the brake holds.
// [RULE_07] A running servo-off is detected on the servo-on input and brake release drops after the running delay.
// [RULE_08] The running brake hold ends early once motor speed falls below 30 r/min.
module sobs_sequencer
   import sobs_pkg::*;
#(
   parameter int UNIT_CYCLES = `SOBS_UNIT_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [4:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdData,
   input  wire logic        servoOnInput,
   input  wire logic        mainPowerLost,
   input  wire logic [15:0] motorSpeedRpm,
   output logic             brakeReleaseOutput,
   output logic             motorEnergized,
   output logic             dynamicBraking,
   output logic             emergencyDecel,
   output logic [9:0]       torqueLimit,
   output logic             counterClear
);

   function automatic sobs_action_t decodeSelect(input logic [3:0] sel);
      sobs_action_t a;
      a.clearCounter = 1'b1;
      if (sel >= `SOBS_ESTOP_SEL_LO) begin
         a.decel = SOBS_STOP_ESTOP;
         a.after = sel[0] ? SOBS_STOP_FREE : SOBS_STOP_DB;
      end else begin
         a.decel = sel[0] ? SOBS_STOP_FREE : SOBS_STOP_DB;
         a.after = sel[1] ? SOBS_STOP_FREE : SOBS_STOP_DB;
         a.clearCounter = (sel < `SOBS_HOLD_SEL_LO);
      end
      return a;
   endfunction

   logic [3:0]   servoOffSelQ;
   logic [3:0]   mainOffSelQ;
   logic [6:0]   stallDlyQ;
   logic [6:0]   runDlyQ;
   logic [9:0]   estopTqQ;
   logic [9:0]   normTqQ;
   sobs_state_t  state_q;
   sobs_state_t  state_d;
   logic [31:0]  preCnt_q;
   logic [6:0]   tickCnt_q;
   logic         unitTick;
   logic         stateChange;
   logic         lowSpeed;
   logic         decelPhase;
   sobs_action_t act;
   logic [31:0]  status;

   assign lowSpeed = (motorSpeedRpm < `SOBS_LOW_SPEED_RPM); // [RULE_08]
   // Both selectors share one decoder so their tables can never drift apart.
   assign act = decodeSelect(mainPowerLost ? mainOffSelQ : servoOffSelQ); // [RULE_02] [RULE_03]

   // Settings writes outside their range are dropped so a bad value never reaches the sequence.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         servoOffSelQ <= `SOBS_RST_SEL; // [RULE_01]
         mainOffSelQ  <= `SOBS_RST_SEL;
         stallDlyQ    <= `SOBS_RST_DLY;
         runDlyQ      <= `SOBS_RST_DLY;
         estopTqQ     <= `SOBS_RST_ESTOP_TQ;
         normTqQ      <= `SOBS_RST_NORM_TQ;
      end else if (regWr) begin
         case (regAddr)
            `SOBS_OFS_SEQ_SEL: begin
               if (regWrData[31:4] == '0 && regWrData[3:0] <= `SOBS_MAX_SEL) servoOffSelQ <= regWrData[3:0]; // [RULE_01]
            end
            `SOBS_OFS_MAIN_SEL: begin
               if (regWrData[31:4] == '0 && regWrData[3:0] <= `SOBS_MAX_SEL) mainOffSelQ <= regWrData[3:0];
            end
            `SOBS_OFS_STALL_DLY: begin
               if (regWrData[31:7] == '0 && regWrData[6:0] <= `SOBS_MAX_DLY) stallDlyQ <= regWrData[6:0];
            end
            `SOBS_OFS_RUN_DLY: begin
               if (regWrData[31:7] == '0 && regWrData[6:0] <= `SOBS_MAX_DLY) runDlyQ <= regWrData[6:0];
            end
            `SOBS_OFS_ESTOP_TQ: begin
               if (regWrData[31:10] == '0 && regWrData[9:0] <= `SOBS_MAX_TQ) estopTqQ <= regWrData[9:0];
            end
            `SOBS_OFS_NORM_TQ: begin
               if (regWrData[31:10] == '0 && regWrData[9:0] <= `SOBS_MAX_TQ) normTqQ <= regWrData[9:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      status = '0;
      status[`SOBS_ST_BRAKE_BIT]  = brakeReleaseOutput;
      status[`SOBS_ST_ENERG_BIT]  = motorEnergized;
      status[`SOBS_ST_DECEL_BIT]  = decelPhase;
      status[`SOBS_ST_LOWSPD_BIT] = lowSpeed;
      status[5:4] = 2'(state_q);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= '0;
      end else if (regRd) begin
         case (regAddr)
            `SOBS_OFS_SEQ_SEL:   regRdData <= {28'h0000000, servoOffSelQ};
            `SOBS_OFS_MAIN_SEL:  regRdData <= {28'h0000000, mainOffSelQ};
            `SOBS_OFS_STALL_DLY: regRdData <= {25'h0000000, stallDlyQ};
            `SOBS_OFS_RUN_DLY:   regRdData <= {25'h0000000, runDlyQ};
            `SOBS_OFS_ESTOP_TQ:  regRdData <= {22'h000000, estopTqQ};
            `SOBS_OFS_NORM_TQ:   regRdData <= {22'h000000, normTqQ};
            `SOBS_OFS_STATUS:    regRdData <= status;
            default:             regRdData <= '0;
         endcase
      end else begin
         regRdData <= '0;
      end
   end

   // The time base restarts on every state change so a delay is never short by up to one count.
   assign stateChange = (state_d != state_q);
   assign unitTick = (preCnt_q == 32'(UNIT_CYCLES - 1));

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         preCnt_q <= '0;
      end else if (stateChange || unitTick) begin
         preCnt_q <= '0;
      end else begin
         preCnt_q <= preCnt_q + 32'h00000001;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tickCnt_q <= '0;
      end else if (stateChange) begin
         tickCnt_q <= '0;
      end else if (unitTick && tickCnt_q != 7'h7f) begin
         tickCnt_q <= tickCnt_q + 7'h01;
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         SOBS_SERVO_ON: begin
            if (!servoOnInput) begin // [RULE_07]
               state_d = lowSpeed ? SOBS_STALL_WAIT : SOBS_RUN_WAIT; // [RULE_05]
            end
         end
         SOBS_STALL_WAIT: begin
            if (servoOnInput) begin
               state_d = SOBS_SERVO_ON;
            end else if (tickCnt_q >= stallDlyQ) begin // [RULE_05]
               state_d = SOBS_SERVO_OFF;
            end
         end
         SOBS_RUN_WAIT: begin
            if (servoOnInput) begin
               state_d = SOBS_SERVO_ON;
            end else if (tickCnt_q >= runDlyQ || lowSpeed) begin // [RULE_07] [RULE_08]
               state_d = SOBS_SERVO_OFF;
            end
         end
         SOBS_SERVO_OFF: begin
            if (servoOnInput) begin
               state_d = SOBS_SERVO_ON;
            end
         end
         default: state_d = SOBS_SERVO_OFF;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SOBS_SERVO_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // The counter clear is one pulse as the servo-off sequence starts.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         counterClear <= 1'b0;
      end else begin
         counterClear <= (state_q == SOBS_SERVO_ON) && !servoOnInput && act.clearCounter; // [RULE_03]
      end
   end

   assign decelPhase = (state_q == SOBS_RUN_WAIT || state_q == SOBS_SERVO_OFF) && !lowSpeed;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         brakeReleaseOutput <= 1'b0;
         motorEnergized     <= 1'b0;
         dynamicBraking     <= 1'b0;
         emergencyDecel     <= 1'b0;
         torqueLimit        <= `SOBS_RST_NORM_TQ;
      end else begin
         brakeReleaseOutput <= (state_d == SOBS_SERVO_ON) || (state_d == SOBS_RUN_WAIT); // [RULE_05] [RULE_07]
         emergencyDecel     <= decelPhase && (act.decel == SOBS_STOP_ESTOP); // [RULE_03]
         motorEnergized     <= (state_d == SOBS_SERVO_ON) || (state_d == SOBS_STALL_WAIT) ||
                               (decelPhase && act.decel == SOBS_STOP_ESTOP); // [RULE_05]
         if (state_d == SOBS_SERVO_ON || state_d == SOBS_STALL_WAIT) begin
            dynamicBraking <= 1'b0;
         end else if (decelPhase) begin
            dynamicBraking <= (act.decel == SOBS_STOP_DB);
         end else begin
            dynamicBraking <= (act.after == SOBS_STOP_DB);
         end
         if (decelPhase && act.decel == SOBS_STOP_ESTOP && estopTqQ != '0) begin
            torqueLimit <= estopTqQ; // [RULE_04]
         end else begin
            torqueLimit <= normTqQ;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence sRunning;
      state_q == SOBS_SERVO_ON && !lowSpeed;
   endsequence

   sequence sServoDrop;
      !servoOnInput;
   endsequence

   // A servo-off starts on the edge where the host drops its request while the motor is still held.
   sequence sOffStart;
      state_q == SOBS_SERVO_ON && !servoOnInput;
   endsequence

   sequence sHoldSel;
      servoOffSelQ >= `SOBS_HOLD_SEL_LO && servoOffSelQ < `SOBS_ESTOP_SEL_LO;
   endsequence

   sequence sClearSel;
      servoOffSelQ < `SOBS_HOLD_SEL_LO || servoOffSelQ >= `SOBS_ESTOP_SEL_LO;
   endsequence

   sel_in_range_a: assert property (servoOffSelQ <= `SOBS_MAX_SEL) // [RULE_01]
      else $error("servo-off selector out of range");
   shared_decode_a: assert property (!mainPowerLost |-> act == decodeSelect(servoOffSelQ)) // [RULE_02]
      else $error("servo-off selector decoded wrongly");
   estop_select_a: assert property ((act.decel == SOBS_STOP_ESTOP) ==
                                    ((mainPowerLost ? mainOffSelQ : servoOffSelQ) >= `SOBS_ESTOP_SEL_LO)) // [RULE_03]
      else $error("emergency stop decode mismatch");
   estop_torque_a: assert property (emergencyDecel && estopTqQ != '0 && $stable(estopTqQ) && $stable(emergencyDecel)
                                    |-> torqueLimit == estopTqQ) // [RULE_04]
      else $error("emergency torque limit not applied");
   stall_brake_first_a: assert property ((state_q == SOBS_SERVO_ON && lowSpeed) ##0 sServoDrop
                                         |=> !brakeReleaseOutput && motorEnergized) // [RULE_05]
      else $error("stall servo-off did not drop brake while energized");
   stall_delay_len_a: assert property (state_q == SOBS_STALL_WAIT && !servoOnInput && tickCnt_q < stallDlyQ
                                       |=> state_q == SOBS_STALL_WAIT) // [RULE_05]
      else $error("stall wait ended early");
   run_hold_a: assert property (sRunning ##0 sServoDrop ##1 (!servoOnInput && !lowSpeed && runDlyQ != '0)[*2]
                                |-> brakeReleaseOutput) // [RULE_07]
      else $error("brake release dropped before running delay");
   low_speed_end_a: assert property (state_q == SOBS_RUN_WAIT && lowSpeed && !servoOnInput
                                     |=> !brakeReleaseOutput && state_q == SOBS_SERVO_OFF) // [RULE_08]
      else $error("brake hold not ended at low speed");

   // These tie each output to the sequence state or the selector table one edge after the state that asks for it.
   clear_at_start_a: assert property (sOffStart ##0 !mainPowerLost ##0 sClearSel |=> counterClear) // [RULE_03]
      else $error("counter clear missing at servo-off start");
   hold_no_clear_a: assert property (sOffStart ##0 !mainPowerLost ##0 sHoldSel |=> !counterClear) // [RULE_03]
      else $error("counter cleared although the selector holds it");
   run_start_a: assert property (sOffStart ##0 !lowSpeed |=> brakeReleaseOutput) // [RULE_07]
      else $error("running servo-off did not hold brake release");
   run_hold_end_a: assert property (state_q == SOBS_RUN_WAIT && tickCnt_q >= runDlyQ // [RULE_07]
                                    && !servoOnInput |=> !brakeReleaseOutput)
      else $error("brake release held past running delay");
   stall_deenerg_a: assert property (state_q == SOBS_STALL_WAIT && tickCnt_q >= stallDlyQ // [RULE_05]
                                     && !servoOnInput |=> !motorEnergized && !brakeReleaseOutput)
      else $error("motor still energized after stall delay");
   decel_db_a: assert property (decelPhase && state_d != SOBS_SERVO_ON && act.decel == SOBS_STOP_DB // [RULE_03]
                                |=> dynamicBraking)
      else $error("dynamic braking missing during deceleration");
   decel_free_a: assert property (decelPhase && state_d != SOBS_SERVO_ON && act.decel != SOBS_STOP_DB // [RULE_03]
                                  |=> !dynamicBraking)
      else $error("dynamic braking applied during free-run or emergency deceleration");
   after_free_a: assert property (state_q == SOBS_SERVO_OFF && lowSpeed && !servoOnInput // [RULE_03]
                                  && act.after == SOBS_STOP_FREE |=> !dynamicBraking)
      else $error("dynamic braking applied after stall with free-run selected");
   estop_energ_a: assert property (decelPhase && state_d != SOBS_SERVO_ON && act.decel == SOBS_STOP_ESTOP // [RULE_04]
                                   |=> motorEnergized && emergencyDecel)
      else $error("emergency deceleration not energized");
   normal_torque_a: assert property (!(decelPhase && act.decel == SOBS_STOP_ESTOP && estopTqQ != '0) // [RULE_04]
                                     |=> torqueLimit == $past(normTqQ))
      else $error("normal torque limit not applied");

endmodule

// *** tb/sobs_host_model.sv ***
`timescale 1ns/10ps

// Host controller that owns the servo-on request line.
module sobs_host_model
   import sobs_pkg::*;
#(
   parameter int BRAKE_ACT_CYCLES = 4
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic offReq,
   input  wire logic brakeReleaseOutput,
   output logic      servoOnInput
);
   // The bench programs the stall delay so that it covers BRAKE_ACT_CYCLES.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         servoOnInput <= 1'b1;
      end else begin
         servoOnInput <= !offReq;
      end
   end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/10ps

module tb_top
   import sobs_pkg::*;
;
   localparam int UNIT = 4;
   logic        ref_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, offReq = 1'b0, seenClr = 1'b0;
   logic [4:0]  regAddr = 5'h00;
   logic [31:0] regWrData = 32'h0, regRdData, expQ[$];
   logic        servoOnInput, brakeReleaseOutput, motorEnergized, dynamicBraking, emergencyDecel, counterClear;
   logic [15:0] motorSpeedRpm = 16'h0000;
   logic [9:0]  torqueLimit;
   logic        rdPend = 1'b0, mainPowerLost = 1'b0;
   int          numErrors = 0, numChecks = 0, cycles = 0, n, s;
   integer      seed = 32'h2fff;

   always #5 ref_clk = ~ref_clk;

   sobs_sequencer #(.UNIT_CYCLES(UNIT)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .servoOnInput(servoOnInput), .mainPowerLost(mainPowerLost), .motorSpeedRpm(motorSpeedRpm),
      .brakeReleaseOutput(brakeReleaseOutput), .motorEnergized(motorEnergized),
      .dynamicBraking(dynamicBraking), .emergencyDecel(emergencyDecel), .torqueLimit(torqueLimit),
      .counterClear(counterClear));

   sobs_host_model #(.BRAKE_ACT_CYCLES(UNIT)) host (.ref_clk(ref_clk), .rst_n(rst_n), .offReq(offReq),
      .brakeReleaseOutput(brakeReleaseOutput), .servoOnInput(servoOnInput));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         numErrors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tallyAndFinish();
      if (numErrors == 0 && numChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Read data stand only in the cycle after the strobe, so the monitor samples exactly there.
   always @(posedge ref_clk) begin
      if (rdPend) begin
         chk(regRdData, expQ.pop_front());
      end
      rdPend <= regRd;
      if (counterClear === 1'b1) seenClr <= 1'b1;
      cycles++;
      if (cycles == 20000) begin
         numErrors++;
         tallyAndFinish();
      end
   end

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      expQ.push_back(e);
      @(posedge ref_clk);
      regRd <= 1'b0;
   endtask

   task automatic waitBrake(input logic v);
      n = 0;
      while (brakeReleaseOutput !== v && n < 50) begin
         @(posedge ref_clk) #1;
         n++;
      end
      chk(brakeReleaseOutput, v);
   endtask

   task automatic goOff(input logic [15:0] spd);
      motorSpeedRpm <= spd;
      offReq <= 1'b0;
      waitBrake(1'b1);
      repeat (3) @(posedge ref_clk);
      seenClr <= 1'b0;
      offReq <= 1'b1;
   endtask

   task automatic stallOff(input int sel);
      goOff(16'($unsigned($random(seed)) % 30));
      waitBrake(1'b0);
      chk(motorEnergized, 1'b1);
      n = 0;
      while (motorEnergized === 1'b1 && n < 40) begin
         @(posedge ref_clk) #1;
         n++;
      end
      chk(n >= 4 && n <= 6, 1'b1);
      chk(dynamicBraking, (sel < 8) ? (sel % 4 < 2) : (sel == 8));
      chk(seenClr, sel < 4 || sel > 7);
   endtask

   task automatic runOff(input int sel, input logic [9:0] tq, input logic early);
      goOff(16'd30 + 16'($unsigned($random(seed)) % 900));
      repeat (3) @(posedge ref_clk) #1;
      chk(brakeReleaseOutput, 1'b1);
      chk(dynamicBraking, sel < 8 && sel % 2 == 0);
      chk(emergencyDecel, sel > 7);
      chk(torqueLimit, (sel > 7 && tq != 10'h000) ? tq : 10'h12c);
      if (early) begin
         @(posedge ref_clk);
         motorSpeedRpm <= 16'd29;
         @(posedge ref_clk) #1;
         chk(brakeReleaseOutput, 1'b0);
      end else begin
         n = 0;
         while (brakeReleaseOutput === 1'b1 && n < 40) begin
            @(posedge ref_clk) #1;
            n++;
         end
         chk(n >= 2 * UNIT - 1 && n <= 2 * UNIT + 1, 1'b1);
      end
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(5'h00, 32'h0);
      rd(5'h08, 32'h0);
      rd(5'h0c, 32'h0);
      rd(5'h14, 32'h12c);
      rd(5'h1c, 32'h0);
      wr(5'h00, 32'ha);
      rd(5'h00, 32'h0);
      wr(5'h08, 32'h1);
      wr(5'h0c, 32'h2);
      rd(5'h08, 32'h1);
      for (s = 0; s < 10; s++) begin
         wr(5'h00, s);
         rd(5'h00, s);
         stallOff(s);
         wr(5'h10, (s % 3 == 0) ? 32'h0 : 32'hc8);
         runOff(s, (s % 3 == 0) ? 10'h000 : 10'h0c8, s % 2);
      end
      // With main power lost the other selector must drive the same table.
      wr(5'h00, 32'h0);
      wr(5'h04, 32'h9);
      mainPowerLost <= 1'b1;
      runOff(9, 10'h000, 1'b0);
      tallyAndFinish();
   end
endmodule
